// ==== common/motor_algo_config_regs.vh ====
// Purpose: offsets, field positions and reset values of the algorithm configuration words
// Assumes: words sit at even offsets 0x80..0x9c, 32 bits each
// Notes: field positions cover the speed detect and start-up words only
// Contract
// R1: thirteen 32-bit words at even offsets 80h-9Ch
// R2: controller never writes unlisted reserved offsets
// R3: speed detect word at 80h, resets zero
// R4: bits 30..25 enable detect, brake, coast, reverse, resync, standstill
// R5: bits 24-22 standstill threshold 5..30, 50, 100 mV
// R6: bit 21 brake low side or high side
// R7: bit 20 brake exit by time or current
// R8: brake and coast durations, sixteen codes 10ms-15s
// R9: bits 8-6 standstill brake 1..1000 ms
// R10: bits 5-3 resync minimum emf, code 0 duty-based
// R11: start-up word a at 82h, resets zero
// R12: bits 30-29 select start method
// R13: align ramp rate and align duration codes
// R14: align current limit, code 0 not applicable
// R15: probe rate codes; probe current codes 0,1 inapplicable
// R16: probe release, advance angle, repeat count fields
// R17: first cycle rate bits 3-0, code A undefined
// R18: start-up word b field layout at 84h
// R19: data bytes travel least significant first
// R20: crc mismatch drops the whole write
// R21: reads return last written value, parity included; word b bits 2-0 read back zero
`ifndef MOTOR_ALGO_CONFIG_REGS_VH
`define MOTOR_ALGO_CONFIG_REGS_VH

`define CFG_WORD_COUNT 13
`define CFG_ADDR_W 12
`define OFF_SPEED_DETECT_CONFIG 12'h080
`define OFF_STARTUP_CONFIG_A 12'h082
`define OFF_STARTUP_CONFIG_B 12'h084
`define OFF_LOOP_CONFIG_A 12'h086
`define OFF_LOOP_CONFIG_B 12'h088
`define OFF_LOOP_CONFIG_C 12'h08a
`define OFF_LOOP_CONFIG_D 12'h08c
`define OFF_FIXED_RATE_CONFIG 12'h08e
`define OFF_FIXED_POWER_CONFIG 12'h090
`define OFF_WIDE_ANGLE_TWO_PHASE 12'h096
`define OFF_WIDE_ANGLE_THREE_PHASE 12'h098
`define OFF_COMMUTATION_CONFIG_A 12'h09a
`define OFF_COMMUTATION_CONFIG_B 12'h09c
`define CFG_RESET_VALUE 32'h00000000

// speed detect word
`define SD_PARITY_BIT 31
`define SD_DETECT_EN_BIT 30
`define SD_BRAKE_EN_BIT 29
`define SD_COAST_EN_BIT 28
`define SD_REVERSE_EN_BIT 27
`define SD_RESYNC_EN_BIT 26
`define SD_STANDSTILL_BRK_EN_BIT 25
`define SD_STANDSTILL_THR_LSB 22
`define SD_BRAKE_SIDE_BIT 21
`define SD_BRAKE_EXIT_SEL_BIT 20
`define SD_BRAKE_EXIT_CUR_LSB 17
`define SD_BRAKE_DUR_LSB 13
`define SD_COAST_DUR_LSB 9
`define SD_STANDSTILL_BRK_DUR_LSB 6
`define SD_RESYNC_MIN_LSB 3

// start-up word a
`define SA_METHOD_LSB 29
`define SA_ALIGN_RAMP_LSB 25
`define SA_ALIGN_TIME_LSB 21
`define SA_ALIGN_CUR_LSB 17
`define SA_PROBE_RATE_LSB 14
`define SA_PROBE_CUR_LSB 10
`define SA_PROBE_REL_LSB 8
`define SA_PROBE_ADV_LSB 6
`define SA_PROBE_REP_LSB 4
`define SA_FIRST_RATE_LSB 0
`define SA_FIRST_RATE_UNDEF 4'ha
`define SA_RELEASE_BRAKE 2'h0
`define SA_RELEASE_TRISTATE 2'h1

// start-up word b
`define SB_LIMIT_SRC_BIT 30
`define SB_DUTY_CAP_LSB 27
`define SB_CUR_CAP_LSB 23
`define SB_ACCEL_LIN_LSB 18
`define SB_ACCEL_QUAD_LSB 13
`define SB_HANDOFF_LSB 8
`define SB_AUTO_HANDOFF_BIT 7
`define SB_FIRST_SRC_BIT 6
`define SB_MIN_DUTY_LSB 3
`define SB_READONLY_MASK 32'h00000007

`endif

// ==== rtl/cfg_word_store.v ====
// Purpose: one stored configuration word with a write-protected field
// Assumes: write strobe already validated by the caller
// Notes: read-only bits always read zero
`timescale 1ns/1ns
module cfg_word_store #(
  parameter [31:0] RO_MASK = 32'h00000000
)(
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // write side
  input wire wr_en,
  input wire [31:0] wr_data,
  // stored value
  output reg [31:0] value
);

always @(posedge ref_clk or negedge rstn)
begin
  if (!rstn)
    value <= 32'h00000000;
  else if (wr_en)
    value <= wr_data & ~RO_MASK; // see R21
end

endmodule // cfg_word_store

// ==== rtl/motor_algo_config_regs.v ====
// Purpose: algorithm configuration word bank with decoded start-up fields
// Assumes: a byte-level transfer engine on ref_clk presents packet bytes
// Notes: crc is checked here over the data bytes of the write packet before commit
`timescale 1ns/1ns
`include "motor_algo_config_regs.vh"
module motor_algo_config_regs (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // write packet byte stream
  input wire pkt_start,
  input wire pkt_byte_valid,
  input wire [7:0] pkt_byte,
  input wire pkt_end,
  input wire [11:0] wr_addr,
  input wire wr_crc_en,
  // read port
  input wire rd_en,
  input wire [11:0] rd_addr,
  output reg [31:0] rd_data,
  output reg rd_hit,
  // write result
  output reg wr_done,
  output reg wr_dropped,
  // speed detect controls
  output wire speed_detect_enable,
  output wire brake_enable,
  output wire coast_enable,
  output wire reverse_drive_enable,
  output wire resync_enable,
  output wire standstill_brake_enable,
  output wire [2:0] standstill_emf_threshold,
  output wire brake_switch_side,
  output wire brake_exit_select,
  output wire [2:0] brake_exit_current,
  output wire [3:0] brake_duration,
  output wire [3:0] coast_duration,
  output wire [2:0] standstill_brake_duration,
  output wire [2:0] resync_min_emf,
  output wire resync_min_from_duty,
  // start-up controls
  output wire [1:0] start_method,
  output wire [3:0] align_ramp_rate,
  output wire [3:0] align_duration,
  output wire [3:0] align_current_limit,
  output wire align_limit_valid,
  output wire [2:0] position_probe_rate,
  output wire [3:0] position_probe_current,
  output wire position_probe_current_valid,
  output wire position_probe_release,
  output wire position_probe_release_valid,
  output wire [1:0] position_probe_advance,
  output wire [1:0] position_probe_repeats,
  output wire [3:0] first_cycle_rate,
  output wire first_cycle_rate_valid,
  // second start-up word
  output wire open_loop_limit_source,
  output wire [2:0] open_loop_duty_cap,
  output wire [3:0] open_loop_current_cap,
  output wire [4:0] open_loop_accel_linear,
  output wire [4:0] open_loop_accel_quadratic,
  output wire [4:0] loop_handoff_threshold,
  output wire auto_handoff,
  output wire first_cycle_source,
  output wire [2:0] min_duty,
  // raw bank view
  output wire [32*13-1:0] cfg_words
);

// index to offset table
function [11:0] word_off;
  input integer i;
  begin
    case (i)
      0: word_off = `OFF_SPEED_DETECT_CONFIG;
      1: word_off = `OFF_STARTUP_CONFIG_A;
      2: word_off = `OFF_STARTUP_CONFIG_B;
      3: word_off = `OFF_LOOP_CONFIG_A;
      4: word_off = `OFF_LOOP_CONFIG_B;
      5: word_off = `OFF_LOOP_CONFIG_C;
      6: word_off = `OFF_LOOP_CONFIG_D;
      7: word_off = `OFF_FIXED_RATE_CONFIG;
      8: word_off = `OFF_FIXED_POWER_CONFIG;
      9: word_off = `OFF_WIDE_ANGLE_TWO_PHASE;
      10: word_off = `OFF_WIDE_ANGLE_THREE_PHASE;
      11: word_off = `OFF_COMMUTATION_CONFIG_A;
      default: word_off = `OFF_COMMUTATION_CONFIG_B;
    endcase
  end
endfunction

// crc-8, polynomial x^8+x^2+x+1, msb first
function [7:0] crc8_step;
  input [7:0] crc;
  input [7:0] data;
  integer b;
  reg [7:0] c;
  begin
    c = crc ^ data;
    for (b = 0; b < 8; b = b + 1)
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    crc8_step = c;
  end
endfunction

localparam ST_IDLE = 2'h0;
localparam ST_DATA = 2'h1;
localparam ST_CRC = 2'h2;
localparam ST_HOLD = 2'h3;

reg [1:0] state;
reg [1:0] next_state;
reg [63:0] data_sr;
reg [7:0] crc_acc;
reg [7:0] crc_rx;
reg crc_seen;
reg [3:0] data_len;
wire commit;
wire crc_ok;
wire [31:0] word_q [0:12];

// the first bytes of a packet are header and control word; the data
// engine marks where data starts by pkt_start, crc covers the data bytes only
always @*
begin
  next_state = state;
  case (state)
    ST_IDLE: if (pkt_start) next_state = ST_DATA;
    ST_DATA: if (pkt_end) next_state = ST_HOLD;
    ST_CRC: next_state = ST_HOLD;
    ST_HOLD: next_state = ST_IDLE;
    default: next_state = ST_IDLE;
  endcase
end

always @(posedge ref_clk or negedge rstn)
begin
  if (!rstn)
  begin
    state <= ST_IDLE;
    data_sr <= 64'h0;
    crc_acc <= 8'h00;
    crc_rx <= 8'h00;
    crc_seen <= 1'b0;
    data_len <= 4'h0;
  end
  else
  begin
    state <= next_state;
    if (pkt_start)
    begin
      data_sr <= 64'h0;
      crc_acc <= 8'h00;
      crc_seen <= 1'b0;
      data_len <= 4'h0;
    end
    else if (state == ST_DATA && pkt_byte_valid)
    begin
      // last byte of a crc packet is the check byte, held apart
      if (wr_crc_en && crc_seen)
      begin
        data_sr <= {crc_rx, data_sr[63:8]}; // see R19
        crc_acc <= crc8_step(crc_acc, crc_rx);
        data_len <= data_len + 4'h1;
      end
      else if (!wr_crc_en)
      begin
        data_sr <= {pkt_byte, data_sr[63:8]}; // see R19
        crc_acc <= crc8_step(crc_acc, pkt_byte);
        data_len <= data_len + 4'h1;
      end
      crc_rx <= pkt_byte;
      crc_seen <= 1'b1;
    end
  end
end

// header bytes come before pkt_start; only the trailing 4 or 8 data bytes land
assign crc_ok = !wr_crc_en || (crc_acc == crc_rx);
assign commit = (state == ST_HOLD) && crc_ok; // see R20

wire [63:0] wr_payload;
wire wide_write;
assign wide_write = (data_len >= 4'h8);
assign wr_payload = wide_write ? data_sr : {32'h0, data_sr[63:32]};

genvar gi;
generate
  for (gi = 0; gi < `CFG_WORD_COUNT; gi = gi + 1)
  begin : g_word
    wire hit_lo;
    wire hit_hi;
    assign hit_lo = (wr_addr == word_off(gi)); // see R1
    assign hit_hi = wide_write && (wr_addr + 12'h002 == word_off(gi));
    cfg_word_store #(
      .RO_MASK((gi == 2) ? `SB_READONLY_MASK : 32'h00000000)
    ) u_word (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .wr_en(commit && (hit_lo || hit_hi)), // see R2
      .wr_data(hit_hi ? wr_payload[63:32] : wr_payload[31:0]),
      .value(word_q[gi])
    );
    assign cfg_words[32*gi +: 32] = word_q[gi];
  end
endgenerate

always @(posedge ref_clk or negedge rstn)
begin
  if (!rstn)
  begin
    wr_done <= 1'b0;
    wr_dropped <= 1'b0;
  end
  else
  begin
    wr_done <= commit;
    wr_dropped <= (state == ST_HOLD) && !crc_ok; // see R20
  end
end

// read mux, unmapped offsets return zero with no hit
integer ri;
reg [31:0] next_rd;
reg next_hit;
always @*
begin
  next_rd = 32'h00000000;
  next_hit = 1'b0;
  for (ri = 0; ri < `CFG_WORD_COUNT; ri = ri + 1)
    if (rd_addr == word_off(ri))
    begin
      next_rd = word_q[ri]; // see R21
      next_hit = 1'b1;
    end
end

always @(posedge ref_clk or negedge rstn)
begin
  if (!rstn)
  begin
    rd_data <= `CFG_RESET_VALUE;
    rd_hit <= 1'b0;
  end
  else if (rd_en)
  begin
    rd_data <= next_rd;
    rd_hit <= next_hit;
  end
end

// speed detect word decode, reset zero
wire [31:0] sd;
assign sd = word_q[0]; // see R3
assign speed_detect_enable = sd[`SD_DETECT_EN_BIT]; // see R4
assign brake_enable = sd[`SD_BRAKE_EN_BIT];
assign coast_enable = sd[`SD_COAST_EN_BIT];
assign reverse_drive_enable = sd[`SD_REVERSE_EN_BIT];
assign resync_enable = sd[`SD_RESYNC_EN_BIT];
assign standstill_brake_enable = sd[`SD_STANDSTILL_BRK_EN_BIT];
assign standstill_emf_threshold = sd[`SD_STANDSTILL_THR_LSB +: 3]; // see R5
assign brake_switch_side = sd[`SD_BRAKE_SIDE_BIT]; // see R6
assign brake_exit_select = sd[`SD_BRAKE_EXIT_SEL_BIT]; // see R7
assign brake_exit_current = sd[`SD_BRAKE_EXIT_CUR_LSB +: 3]; // see R7
assign brake_duration = sd[`SD_BRAKE_DUR_LSB +: 4]; // see R8
assign coast_duration = sd[`SD_COAST_DUR_LSB +: 4]; // see R8
assign standstill_brake_duration = sd[`SD_STANDSTILL_BRK_DUR_LSB +: 3]; // see R9
assign resync_min_emf = sd[`SD_RESYNC_MIN_LSB +: 3]; // see R10
assign resync_min_from_duty = (resync_min_emf == 3'h0); // see R10

// start-up word a decode
wire [31:0] sa;
assign sa = word_q[1]; // see R11
assign start_method = sa[`SA_METHOD_LSB +: 2]; // see R12
assign align_ramp_rate = sa[`SA_ALIGN_RAMP_LSB +: 4]; // see R13
assign align_duration = sa[`SA_ALIGN_TIME_LSB +: 4]; // see R13
assign align_current_limit = sa[`SA_ALIGN_CUR_LSB +: 4]; // see R14
assign align_limit_valid = (align_current_limit != 4'h0); // see R14
assign position_probe_rate = sa[`SA_PROBE_RATE_LSB +: 3]; // see R15
assign position_probe_current = sa[`SA_PROBE_CUR_LSB +: 4]; // see R15
assign position_probe_current_valid = (position_probe_current > 4'h1); // see R15
assign position_probe_release = sa[`SA_PROBE_REL_LSB]; // see R16
assign position_probe_release_valid = (sa[`SA_PROBE_REL_LSB +: 2] == `SA_RELEASE_BRAKE) ||
                                      (sa[`SA_PROBE_REL_LSB +: 2] == `SA_RELEASE_TRISTATE); // see R16
assign position_probe_advance = sa[`SA_PROBE_ADV_LSB +: 2]; // see R16
assign position_probe_repeats = sa[`SA_PROBE_REP_LSB +: 2]; // see R16
assign first_cycle_rate = sa[`SA_FIRST_RATE_LSB +: 4]; // see R17
assign first_cycle_rate_valid = (first_cycle_rate != `SA_FIRST_RATE_UNDEF); // see R17

// start-up word b decode
wire [31:0] sb;
assign sb = word_q[2];
assign open_loop_limit_source = sb[`SB_LIMIT_SRC_BIT]; // see R18
assign open_loop_duty_cap = sb[`SB_DUTY_CAP_LSB +: 3];
assign open_loop_current_cap = sb[`SB_CUR_CAP_LSB +: 4];
assign open_loop_accel_linear = sb[`SB_ACCEL_LIN_LSB +: 5];
assign open_loop_accel_quadratic = sb[`SB_ACCEL_QUAD_LSB +: 5];
assign loop_handoff_threshold = sb[`SB_HANDOFF_LSB +: 5]; // see R18
assign auto_handoff = sb[`SB_AUTO_HANDOFF_BIT];
assign first_cycle_source = sb[`SB_FIRST_SRC_BIT];
assign min_duty = sb[`SB_MIN_DUTY_LSB +: 3];

endmodule // motor_algo_config_regs

// ==== verif/ctrl_model.sv ====
// Purpose: controller-side model streaming one write packet
// Assumes: bank samples on rising edge, model drives on falling
// Notes: crc-8 poly 07, init 0, over the data bytes only
`timescale 1ns/1ns
module ctrl_model (
  // clock
  input wire ref_clk,
  // packet stream
  output reg pkt_start,
  output reg pkt_byte_valid,
  output reg [7:0] pkt_byte,
  output reg pkt_end
);
  initial {pkt_start, pkt_byte_valid, pkt_byte, pkt_end} = 11'h0;
  // n is 4 for one word or 8 for two neighbouring words
  task send(input [63:0] w, input integer n, input crc_on, input bad);
    reg [7:0] c;
    integer k, b;
    begin
      c = 8'h00;
      @(negedge ref_clk) pkt_start = 1'b1;
      for (k = 0; k <= n; k = k + 1)
      begin
        @(negedge ref_clk);
        pkt_start = 1'b0;
        pkt_byte_valid = (k < n) || crc_on;
        pkt_byte = (k < n) ? w[8*k +: 8] : c ^ {7'h0, bad};
        for (b = 0; b < 8 && k < n; b = b + 1)
          c = {c[6:0], 1'b0} ^ ((c[7] ^ pkt_byte[7-b]) ? 8'h07 : 8'h00);
      end
      @(negedge ref_clk);
      pkt_byte_valid = 1'b0;
      pkt_end = 1'b1;
      // released byte lane must not keep the last value
      pkt_byte = ~pkt_byte;
      @(negedge ref_clk) pkt_end = 1'b0;
    end
  endtask
endmodule // ctrl_model

// ==== verif/motor_algo_config_regs_props.sv ====
// Purpose: timing and mapping checks at the bank ports
// Assumes: one packet in flight at a time
// Notes: bound to the bank below
`timescale 1ns/1ns
module motor_algo_config_regs_props (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // write result
  input wire pkt_end,
  input wire wr_done,
  input wire wr_dropped,
  // read port
  input wire rd_en,
  input wire [11:0] rd_addr,
  input wire [31:0] rd_data,
  input wire rd_hit,
  // decoded and raw view
  input wire speed_detect_enable,
  input wire [2:0] standstill_emf_threshold,
  input wire first_cycle_rate_valid,
  input wire [32*13-1:0] cfg_words
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_answer;
    ##1 !(wr_done || wr_dropped) ##1 (wr_done || wr_dropped);
  endsequence
  sequence s_gone;
    ##1 !(wr_done || wr_dropped);
  endsequence
  a_write_answer: assert property (pkt_end |-> s_answer)
    else $error("write answer late");
  a_answer_pulse: assert property ((wr_done || wr_dropped) |-> s_gone)
    else $error("answer not a pulse");
  a_drop_keeps: assert property (wr_dropped |-> !wr_done && $stable(cfg_words))
    else $error("dropped write changed bank");
  a_change_cause: assert property ($changed(cfg_words) |-> wr_done)
    else $error("bank changed without write");
  a_read_hole: assert property (rd_en && rd_addr == 12'h092 |=> !rd_hit && rd_data == 32'h0)
    else $error("unmapped read");
  a_read_word: assert property (rd_en && rd_addr == 12'h080 |=> rd_hit && rd_data == $past(cfg_words[31:0]))
    else $error("read of first word");
  a_read_holds: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved");
  a_ro_field: assert property (cfg_words[66:64] == 3'h0)
    else $error("read-only field set");
  a_detect_map: assert property (speed_detect_enable == cfg_words[30] && standstill_emf_threshold == cfg_words[24:22])
    else $error("detect field map");
  a_rate_valid: assert property (first_cycle_rate_valid == (cfg_words[35:32] != 4'ha))
    else $error("rate valid flag");
endmodule // motor_algo_config_regs_props
bind motor_algo_config_regs motor_algo_config_regs_props i_props (.ref_clk(ref_clk), .rstn(rstn),
  .pkt_end(pkt_end), .wr_done(wr_done), .wr_dropped(wr_dropped), .rd_en(rd_en), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_hit(rd_hit), .speed_detect_enable(speed_detect_enable),
  .standstill_emf_threshold(standstill_emf_threshold), .first_cycle_rate_valid(first_cycle_rate_valid),
  .cfg_words(cfg_words));

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the configuration word bank
// Assumes: packets come from ctrl_model one at a time
// Notes: random words from a fixed-seed lfsr
`timescale 1ns/1ns
module tb;
  reg ref_clk = 1'b0;
  reg rstn = 1'b0;
  reg rd_en = 1'b0;
  reg wr_crc_en = 1'b0;
  reg [11:0] rd_addr = 12'h000;
  reg [11:0] wr_addr = 12'h000;
  reg [31:0] seed = 32'h43fe8490;
  reg [31:0] mdl [0:12];
  reg [31:0] d;
  integer error_cnt = 0;
  integer comparisons = 0;
  integer k, p;
  wire pkt_start, pkt_byte_valid, pkt_end, rd_hit, wr_done, wr_dropped, rel;
  wire [7:0] pkt_byte, sa_lo;
  wire [31:0] rd_data;
  wire [27:0] sd_f, sb_f;
  wire [20:0] sa_hi;
  wire [4:0] flg;
  wire [415:0] cfg_words;
  always #5 ref_clk = ~ref_clk;
  ctrl_model i_ctrl_model (.ref_clk(ref_clk), .pkt_start(pkt_start), .pkt_byte_valid(pkt_byte_valid),
    .pkt_byte(pkt_byte), .pkt_end(pkt_end));
  motor_algo_config_regs i_motor_algo_config_regs (.ref_clk(ref_clk), .rstn(rstn), .pkt_start(pkt_start),
    .pkt_byte_valid(pkt_byte_valid), .pkt_byte(pkt_byte), .pkt_end(pkt_end), .wr_addr(wr_addr),
    .wr_crc_en(wr_crc_en), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit),
    .wr_done(wr_done), .wr_dropped(wr_dropped), .speed_detect_enable(sd_f[27]), .brake_enable(sd_f[26]),
    .coast_enable(sd_f[25]), .reverse_drive_enable(sd_f[24]), .resync_enable(sd_f[23]),
    .standstill_brake_enable(sd_f[22]), .standstill_emf_threshold(sd_f[21:19]), .brake_switch_side(sd_f[18]),
    .brake_exit_select(sd_f[17]), .brake_exit_current(sd_f[16:14]), .brake_duration(sd_f[13:10]),
    .coast_duration(sd_f[9:6]), .standstill_brake_duration(sd_f[5:3]), .resync_min_emf(sd_f[2:0]),
    .resync_min_from_duty(flg[0]), .start_method(sa_hi[20:19]), .align_ramp_rate(sa_hi[18:15]),
    .align_duration(sa_hi[14:11]), .align_current_limit(sa_hi[10:7]), .align_limit_valid(flg[1]),
    .position_probe_rate(sa_hi[6:4]), .position_probe_current(sa_hi[3:0]), .position_probe_current_valid(flg[2]),
    .position_probe_release(rel), .position_probe_release_valid(flg[3]), .position_probe_advance(sa_lo[7:6]),
    .position_probe_repeats(sa_lo[5:4]), .first_cycle_rate(sa_lo[3:0]), .first_cycle_rate_valid(flg[4]),
    .open_loop_limit_source(sb_f[27]), .open_loop_duty_cap(sb_f[26:24]), .open_loop_current_cap(sb_f[23:20]),
    .open_loop_accel_linear(sb_f[19:15]), .open_loop_accel_quadratic(sb_f[14:10]),
    .loop_handoff_threshold(sb_f[9:5]), .auto_handoff(sb_f[4]), .first_cycle_source(sb_f[3]),
    .min_duty(sb_f[2:0]), .cfg_words(cfg_words));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // offsets 92h and 94h are holes in the map
  function [11:0] off(input integer i);
    off = (i < 9) ? 12'h080 + 12'(2 * i) : 12'h096 + 12'(2 * i - 18);
  endfunction
  task check(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task rd(input [11:0] a);
    begin
      @(negedge ref_clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge ref_clk);
      rd_en = 1'b0;
      d = rd_data;
    end
  endtask
  task wr(input integer i, input [63:0] w, input wide, input c, input bad);
    integer n;
    begin
      wr_addr = off(i);
      wr_crc_en = c;
      i_ctrl_model.send(w, wide ? 8 : 4, c, bad);
      n = 0;
      while (wr_done !== 1'b1 && wr_dropped !== 1'b1 && n < 8)
      begin
        @(negedge ref_clk);
        n = n + 1;
      end
      check({wr_done, wr_dropped}, {!bad, bad});
      if (!bad)
      begin
        mdl[i] = (i == 2) ? w[31:0] & ~32'h7 : w[31:0];
        if (wide)
          mdl[i + 1] = (i + 1 == 2) ? w[63:32] & ~32'h7 : w[63:32];
      end
      rd(off(i));
      check(d, mdl[i]);
      check(rd_hit, 1'b1);
      check(cfg_words[32*i +: 32], mdl[i]);
      if (wide)
      begin
        rd(off(i + 1));
        check(d, mdl[i + 1]);
        check(cfg_words[32*(i+1) +: 32], mdl[i + 1]);
      end
    end
  endtask
  task fields;
    begin
      check(sd_f, mdl[0][30:3]);
      check(sa_hi, mdl[1][30:10]);
      check({sa_lo, rel}, {mdl[1][7:0], mdl[1][8]});
      check(flg, {mdl[1][3:0] != 4'ha, !mdl[1][9], mdl[1][13:10] > 1, mdl[1][20:17] != 0, mdl[0][5:3] == 0});
      check(sb_f, mdl[2][30:3]);
    end
  endtask
  initial
  begin
    // about 50 packets of under 20 cycles plus reads; wide margin
    #200000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    for (k = 0; k < 13; k = k + 1)
    begin
      mdl[k] = 32'h0;
      rd(off(k));
      check(d, 32'h0);
      check(rd_hit, 1'b1);
    end
    rd(12'h092);
    check(rd_hit, 1'b0);
    check(d, 32'h0);
    fields;
    for (p = 0; p < 3; p = p + 1)
      for (k = 0; k < 13; k = k + 1)
      begin
        seed = lfsr(seed);
        wr(k, p == 0 ? 32'hffffffff : seed, 1'b0, seed[7], 1'b0);
      end
    fields;
    // every start method, plus inapplicable and undefined codes
    for (p = 0; p < 4; p = p + 1)
    begin
      seed = lfsr(seed);
      wr(0, {seed[31:6], 3'(p), seed[2:0]}, 1'b0, 1'b0, 1'b0);
      wr(1, {seed[31], 2'(p), seed[28:21], 4'(p), seed[16:14], 4'(p), 2'(p), seed[7:4], p[0] ? 4'ha : seed[3:0]},
        1'b0, seed[9], 1'b0);
      fields;
    end
    // eight data bytes fill two neighbouring words, second one keeps its read-only bits clear
    seed = lfsr(seed);
    wr(1, {lfsr(seed), seed}, 1'b1, seed[4], 1'b0);
    fields;
    seed = lfsr(seed);
    wr(1, seed, 1'b0, 1'b1, 1'b1);
    end_sim;
  end
endmodule // tb
